// File: adcsq_top.sv
// top: registers, sequencer, flags and result storage of the converter controller
// What this block does
// - a mode register write while powered up starts a new sequence with the new settings
// - a mode write during a sequence aborts it and clears all complete flags
// - length bit 0 gives four conversions, 1 gives eight
// - scan 0 runs one sequence, scan 1 repeats sequences forever
// - single-channel mode converts the one selected channel every time
// - multichannel mode converts consecutive channels, conversion k to result k
// - select 00xx inputs 0-3, 01xx inputs 4-7, 10xx reserved, 11xx references
// - multichannel ignores in-group select bits; single mode decodes all four
// - sequence flag sets at end of single sequence or first scan sequence
// - sequence flag clears on mode write, or first result read in fast clear
// - status shows the 3-bit counter of the next result register
// - each result flag sets on its conversion and holds until read clears
// - fast clear: result read clears; else a status read must come first
// - status registers read-only, writable in special mode
// - test register only in special mode, else reads zero, ignores writes
// - mode register is readable and writable at any time
// - with interrupt enable set, end of a single sequence or first scan sequence raises the interrupt flag
// - conversion is 2 sample, 4 transfer, 2/4/8/16 final, 10 resolution clocks
// - results stored left-justified unsigned at the counter's register
// - clearing power-up aborts the sequence; registers stay accessible
module adcsq_top #(
   parameter int NUM_INPUTS = 8
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic special_mode,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic [7:0] analog_input [NUM_INPUTS],
   input wire logic [7:0] high_reference,
   input wire logic [7:0] low_reference,
   output logic [4:0] channel_sel,
   output logic sequence_irq
);
   logic [7:0] ctl2_ff;
   logic [7:0] ctl4_ff;
   logic [7:0] mode_ff;
   logic [7:0] test_ff;
   logic [7:0] result_ff [8];
   logic [7:0] ccf_ff;
   logic [7:0] stat_seen_ff;
   logic scf_ff;
   logic [2:0] cnt_ff;
   logic running_ff;
   logic first_done_ff;
   logic pending_ff;
   logic tick;
   logic conv_busy;
   logic conv_done;
   logic [7:0] conv_result;
   logic [7:0] sample;
   logic abort;
   logic mode_wr;
   logic is_res;
   logic [2:0] res_idx;
   logic res_rd;
   logic last_conv;
   logic [7:0] ccf_set;
   logic [7:0] ccf_clr;
   logic [4:0] nxt_sel;
   ///////////////////////////////////////////////////////////////////
   // decode helpers
   function automatic logic [4:0] chan_decode(input logic [7:0] mode, input logic [2:0] cnt);
      logic [3:0] s;
      s = mode[3:0];
      if (mode[adcsq_pkg::MODE_MULTICHANNEL_ENABLE]) begin
         if (mode[adcsq_pkg::MODE_LEN]) s = {s[3], cnt};
         else s = {s[3:2], cnt[1:0]};
      end
      case (s[3:2])
         2'b00: chan_decode = {3'b000, s[1:0]};
         2'b01: chan_decode = {3'b001, s[1:0]};
         2'b11: chan_decode = {3'b100, s[1:0]};
         default: chan_decode = adcsq_pkg::SEL_RSVD;
      endcase
   endfunction
   function automatic logic [7:0] pick_sample(input logic [4:0] sel, input logic [7:0] hi,
                                             input logic [7:0] lo, input logic [7:0] an);
      case (sel)
         adcsq_pkg::SEL_VRH: pick_sample = hi;
         adcsq_pkg::SEL_VRL: pick_sample = lo;
         adcsq_pkg::SEL_MID: pick_sample = 8'((9'(hi) + 9'(lo)) >> 1);
         adcsq_pkg::SEL_TEST: pick_sample = 8'h00;
         adcsq_pkg::SEL_RSVD: pick_sample = 8'h00;
         default: pick_sample = an;
      endcase
   endfunction
   ///////////////////////////////////////////////////////////////////
   // bus decode
   assign mode_wr = wr && (addr == adcsq_pkg::OFS_MODE);
   assign is_res = (addr >= adcsq_pkg::OFS_RES0) && (addr <= adcsq_pkg::OFS_RES_LAST) && !addr[0];
   assign res_idx = addr[3:1];
   assign res_rd = rd && is_res;
   assign abort = mode_wr || (wr && (addr == adcsq_pkg::OFS_CTL2 || addr == adcsq_pkg::OFS_CTL4))
                  || !ctl2_ff[adcsq_pkg::CTL2_PWR];
   assign last_conv = mode_ff[adcsq_pkg::MODE_LEN] ? (cnt_ff == 3'h7) : (cnt_ff == 3'h3);
   assign nxt_sel = chan_decode(mode_ff, cnt_ff);
   assign sample = pick_sample(nxt_sel, high_reference, low_reference,
                               analog_input[nxt_sel[2:0]]);
   ///////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ctl2_ff <= adcsq_pkg::RST_CTL2;
         ctl4_ff <= adcsq_pkg::RST_CTL4;
         mode_ff <= adcsq_pkg::RST_MODE;
         test_ff <= 8'h00;
      end else begin
         if (wr && addr == adcsq_pkg::OFS_CTL2) begin
            ctl2_ff[7:1] <= wdata[7:1] & adcsq_pkg::MASK_CTL2[7:1];
         end
         if (mode_wr) begin
            mode_ff <= wdata & adcsq_pkg::MASK_MODE;
         end
         if (wr && addr == adcsq_pkg::OFS_CTL4) begin
            ctl4_ff <= wdata & adcsq_pkg::MASK_CTL4;
         end
         if (wr && addr == adcsq_pkg::OFS_TEST && special_mode) begin
            test_ff <= wdata;
         end
         if (conv_done && last_conv && !first_done_ff && ctl2_ff[adcsq_pkg::CTL2_IRQE]) begin
            ctl2_ff[adcsq_pkg::CTL2_IRQF] <= 1'b1;
         end else if (mode_wr || (wr && addr == adcsq_pkg::OFS_CTL2)) begin
            ctl2_ff[adcsq_pkg::CTL2_IRQF] <= 1'b0;
         end
      end
   end
   ///////////////////////////////////////////////////////////////////
   // sequencer
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         running_ff <= 1'b0;
         pending_ff <= 1'b0;
         cnt_ff <= 3'h0;
         first_done_ff <= 1'b0;
      end else if (abort) begin
         running_ff <= mode_wr && ctl2_ff[adcsq_pkg::CTL2_PWR];
         pending_ff <= mode_wr && ctl2_ff[adcsq_pkg::CTL2_PWR];
         cnt_ff <= 3'h0;
         first_done_ff <= 1'b0;
      end else if (running_ff) begin
         pending_ff <= 1'b0;
         if (conv_done) begin
            if (last_conv) begin
               cnt_ff <= 3'h0;
               first_done_ff <= 1'b1;
               running_ff <= mode_ff[adcsq_pkg::MODE_SCAN];
               pending_ff <= mode_ff[adcsq_pkg::MODE_SCAN];
            end else begin
               cnt_ff <= cnt_ff + 3'h1;
               pending_ff <= 1'b1;
            end
         end
      end
   end
   ///////////////////////////////////////////////////////////////////
   // results and flags
   always_comb begin
      ccf_set = 8'h00;
      ccf_clr = 8'h00;
      if (conv_done && !abort) ccf_set[cnt_ff] = 1'b1;
      if (res_rd && (ctl2_ff[adcsq_pkg::CTL2_FFC] || stat_seen_ff[res_idx])) begin
         ccf_clr[res_idx] = 1'b1;
      end
   end
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < 8; i++) result_ff[i] <= 8'h00;
      end else if (conv_done && !abort) begin
         result_ff[cnt_ff] <= conv_result;
      end
   end
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ccf_ff <= 8'h00;
         stat_seen_ff <= 8'h00;
         scf_ff <= 1'b0;
      end else begin
         if (mode_wr) begin
            ccf_ff <= 8'h00;
            stat_seen_ff <= 8'h00;
         end else if (wr && special_mode && addr == adcsq_pkg::OFS_STAT1) begin
            ccf_ff <= wdata | ccf_set;
         end else begin
            ccf_ff <= (ccf_ff & ~ccf_clr) | ccf_set;
            if (rd && (addr == adcsq_pkg::OFS_STAT0 || addr == adcsq_pkg::OFS_STAT1)) begin
               stat_seen_ff <= ccf_ff;
            end else begin
               stat_seen_ff <= stat_seen_ff & ~ccf_clr;
            end
         end
         if (conv_done && last_conv && !first_done_ff && !abort) begin
            scf_ff <= 1'b1;
         end else if (mode_wr) begin
            scf_ff <= 1'b0;
         end else if (res_rd && ctl2_ff[adcsq_pkg::CTL2_FFC]) begin
            scf_ff <= 1'b0;
         end else if (wr && special_mode && addr == adcsq_pkg::OFS_STAT0) begin
            scf_ff <= wdata[adcsq_pkg::STAT_SCF];
         end
      end
   end
   ///////////////////////////////////////////////////////////////////
   // read data and outputs
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= 8'h00;
         channel_sel <= 5'h00;
         sequence_irq <= 1'b0;
      end else begin
         channel_sel <= nxt_sel;
         sequence_irq <= ctl2_ff[adcsq_pkg::CTL2_IRQF] && ctl2_ff[adcsq_pkg::CTL2_IRQE];
         rdata <= 8'h00;
         if (rd) begin
            if (is_res) rdata <= result_ff[res_idx];
            else begin
               case (addr)
                  adcsq_pkg::OFS_CTL2: rdata <= ctl2_ff;
                  adcsq_pkg::OFS_CTL4: rdata <= ctl4_ff;
                  adcsq_pkg::OFS_MODE: rdata <= mode_ff;
                  adcsq_pkg::OFS_STAT0: rdata <= {scf_ff, 4'h0, cnt_ff};
                  adcsq_pkg::OFS_STAT1: rdata <= ccf_ff;
                  adcsq_pkg::OFS_TEST: rdata <= special_mode ? test_ff : 8'h00;
                  default: rdata <= 8'h00;
               endcase
            end
         end
      end
   end
   ///////////////////////////////////////////////////////////////////
   // converter clock and conversion engine; is up to software
   adcsq_prescale u_pre (
      .clock(clock),
      .reset_n(reset_n),
      .enable(ctl2_ff[adcsq_pkg::CTL2_PWR]),
      .divide(ctl4_ff[4:0]),
      .tick(tick)
   );
   adcsq_conv u_conv (
      .clock(clock),
      .reset_n(reset_n),
      .tick(tick),
      .abort(abort),
      .start(pending_ff && running_ff && !conv_busy),
      .smp_sel(ctl4_ff[6:5]),
      .sample(sample),
      .busy(conv_busy),
      .done(conv_done),
      .result(conv_result)
   );
endmodule

// File: adcsq_pkg.sv
// package: register map, field positions, reset values and timing for the sequencer
package adcsq_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam logic [7:0] OFS_CTL2 = 8'h62;
   localparam logic [7:0] OFS_CTL4 = 8'h64;
   localparam logic [7:0] OFS_MODE = 8'h65;
   localparam logic [7:0] OFS_STAT0 = 8'h66;
   localparam logic [7:0] OFS_STAT1 = 8'h67;
   localparam logic [7:0] OFS_TEST = 8'h68;
   localparam logic [7:0] OFS_RES0 = 8'h70;
   localparam logic [7:0] OFS_RES_LAST = 8'h7e;
   localparam int MODE_LEN = 6;
   localparam int MODE_SCAN = 5;
   localparam int MODE_MULTICHANNEL_ENABLE = 4;
   localparam int CTL2_PWR = 7;
   localparam int CTL2_FFC = 6;
   localparam int CTL2_IRQE = 1;
   localparam int CTL2_IRQF = 0;
   localparam int STAT_SCF = 7;
   localparam logic [7:0] RST_CTL2 = 8'h00;
   localparam logic [7:0] RST_CTL4 = 8'h01;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] MASK_CTL2 = 8'hc3;
   localparam logic [7:0] MASK_CTL4 = 8'h7f;
   localparam logic [7:0] MASK_MODE = 8'h7f;
   localparam logic [4:0] INIT_SAMPLE_CLKS = 5'h02;
   localparam logic [4:0] TRANSFER_CLKS = 5'h04;
   localparam logic [4:0] RESOLVE_CLKS = 5'h0a;
   localparam logic [4:0] SEL_VRH = 5'h10;
   localparam logic [4:0] SEL_VRL = 5'h11;
   localparam logic [4:0] SEL_MID = 5'h12;
   localparam logic [4:0] SEL_TEST = 5'h13;
   localparam logic [4:0] SEL_RSVD = 5'h1f;
   typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_SAMPLE, ADCSQ_XFER, ADCSQ_RESOLVE} adcsq_phase_t;
endpackage

// File: adcsq_prescale.sv
// converter clock tick generator from the peripheral clock
module adcsq_prescale (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic enable,
   input wire logic [4:0] divide,
   output logic tick
);
   logic [4:0] cnt_ff;
   logic half_ff;
   ///////////////////////////////////////////////////////////////////
   // counts divide+1, then a divide by two gives one tick per period
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cnt_ff <= 5'h00;
         half_ff <= 1'b0;
         tick <= 1'b0;
      end else if (!enable) begin
         cnt_ff <= 5'h00;
         half_ff <= 1'b0;
         tick <= 1'b0;
      end else if (cnt_ff >= divide) begin
         cnt_ff <= 5'h00;
         half_ff <= ~half_ff;
         tick <= half_ff;
      end else begin
         cnt_ff <= cnt_ff + 5'h01;
         tick <= 1'b0;
      end
   end
endmodule

// File: adcsq_conv.sv
// one conversion: phase timing and channel sample capture
module adcsq_conv (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic tick,
   input wire logic abort,
   input wire logic start,
   input wire logic [1:0] smp_sel,
   input wire logic [7:0] sample,
   output logic busy,
   output logic done,
   output logic [7:0] result
);
   adcsq_pkg::adcsq_phase_t phase_ff;
   logic [4:0] cnt_ff;
   logic [4:0] final_clks;
   always_comb begin
      final_clks = 5'h02 << smp_sel;
   end
   assign busy = (phase_ff != adcsq_pkg::ADCSQ_IDLE);
   ///////////////////////////////////////////////////////////////////
   // phases: initial sample, transfer, final sample, resolution
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         phase_ff <= adcsq_pkg::ADCSQ_IDLE;
         cnt_ff <= 5'h00;
         done <= 1'b0;
         result <= 8'h00;
      end else begin
         done <= 1'b0;
         if (abort) begin
            phase_ff <= adcsq_pkg::ADCSQ_IDLE;
            cnt_ff <= 5'h00;
         end else begin
            case (phase_ff)
               adcsq_pkg::ADCSQ_IDLE: begin
                  if (start) begin
                     phase_ff <= adcsq_pkg::ADCSQ_SAMPLE;
                     cnt_ff <= adcsq_pkg::INIT_SAMPLE_CLKS;
                  end
               end
               adcsq_pkg::ADCSQ_SAMPLE: begin
                  if (tick) begin
                     cnt_ff <= cnt_ff - 5'h01;
                     if (cnt_ff == 5'h01) begin
                        phase_ff <= adcsq_pkg::ADCSQ_XFER;
                        cnt_ff <= adcsq_pkg::TRANSFER_CLKS + final_clks;
                        result <= sample;
                     end
                  end
               end
               adcsq_pkg::ADCSQ_XFER: begin
                  if (tick) begin
                     cnt_ff <= cnt_ff - 5'h01;
                     if (cnt_ff == 5'h01) begin
                        phase_ff <= adcsq_pkg::ADCSQ_RESOLVE;
                        cnt_ff <= adcsq_pkg::RESOLVE_CLKS;
                     end
                  end
               end
               adcsq_pkg::ADCSQ_RESOLVE: begin
                  if (tick) begin
                     cnt_ff <= cnt_ff - 5'h01;
                     if (cnt_ff == 5'h01) begin
                        phase_ff <= adcsq_pkg::ADCSQ_IDLE;
                        done <= 1'b1;
                     end
                  end
               end
               default: phase_ff <= adcsq_pkg::ADCSQ_IDLE;
            endcase
         end
      end
   end
endmodule

// File: adcsq_top_props.sv
// checker: bus-visible properties of the converter sequencer
module adcsq_top_props (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic special_mode,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic [4:0] channel_sel,
   input wire logic sequence_irq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   logic [7:0] mode_ff;
   logic mode_wr;
   logic [3:0] grp;
   logic [4:0] base_sel;
   logic [4:0] sgl_sel;
   assign mode_wr = wr && addr == adcsq_pkg::OFS_MODE;
   assign grp = mode_ff[6] ? {mode_ff[3], 3'b000} : {mode_ff[3:2], 2'b00};
   assign base_sel = grp[3:2] == 2'b10 ? adcsq_pkg::SEL_RSVD :
      grp[3:2] == 2'b11 ? adcsq_pkg::SEL_VRH : {2'b00, grp[2:0]};
   assign sgl_sel = mode_ff[3:2] == 2'b10 ? adcsq_pkg::SEL_RSVD :
      mode_ff[3:2] == 2'b11 ? {3'b100, mode_ff[1:0]} : {2'b00, mode_ff[2:0]};
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         mode_ff <= 8'h00;
      end else if (mode_wr) begin
         mode_ff <= wdata;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   property p_mode_rw;
      mode_wr ##2 (rd && addr == adcsq_pkg::OFS_MODE) |=> rdata == (mode_ff & 8'h7f);
   endproperty
   a_mode_rw: assert property (p_mode_rw) else $error("mode readback wrong");
   property p_ctl4_rw;
      wr && addr == adcsq_pkg::OFS_CTL4 ##2 (rd && addr == adcsq_pkg::OFS_CTL4)
         |=> rdata == ($past(wdata, 3) & adcsq_pkg::MASK_CTL4);
   endproperty
   a_ctl4_rw: assert property (p_ctl4_rw) else $error("ctl4 readback wrong");
   property p_test_zero;
      rd && addr == adcsq_pkg::OFS_TEST && !special_mode |=> rdata == 8'h00;
   endproperty
   a_test_zero: assert property (p_test_zero) else $error("test reg not zero");
   property p_scf_clr;
      mode_wr ##2 (rd && addr == adcsq_pkg::OFS_STAT0) |=> rdata == 8'h00;
   endproperty
   a_scf_clr: assert property (p_scf_clr) else $error("status not cleared");
   property p_ccf_clr;
      mode_wr ##4 (rd && addr == adcsq_pkg::OFS_STAT1) |=> rdata == 8'h00;
   endproperty
   a_ccf_clr: assert property (p_ccf_clr) else $error("flags not cleared");
   property p_irq_quiet;
      mode_wr |-> ##2 !sequence_irq [*8];
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("irq early");
   property p_chsel_single;
      mode_wr && !wdata[4] |-> ##4 channel_sel == sgl_sel;
   endproperty
   a_chsel_single: assert property (p_chsel_single) else $error("single sel wrong");
   property p_chsel_multi;
      mode_wr && wdata[4] |-> ##4 channel_sel == base_sel;
   endproperty
   a_chsel_multi: assert property (p_chsel_multi) else $error("group sel wrong");
   c_scan: cover property (mode_wr && wdata[5]);
   c_res: cover property (rd && addr == adcsq_pkg::OFS_RES0);
   c_irq: cover property ($rose(sequence_irq));
endmodule
bind adcsq_top adcsq_top_props u_props (.clock(clock), .reset_n(reset_n),
   .special_mode(special_mode), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .channel_sel(channel_sel), .sequence_irq(sequence_irq));

// File: adcsq_top_test.sv
// testbench: register-level scenarios of the converter sequencer
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin mismatches++; \
   $display("ERROR %s expected %h seen %h", n, e, s); end end
module adcsq_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic special_mode = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic [7:0] ain [8];
   logic [7:0] hi_ref = 8'hf0;
   logic [7:0] lo_ref = 8'h10;
   logic [4:0] channel_sel;
   logic sequence_irq;
   logic [7:0] d;
   logic [7:0] modes [6] = '{8'h10, 8'h17, 8'h50, 8'h58, 8'h06, 8'h4d};
   int mismatches = 0;
   int cmp_count = 0;
   adcsq_top dut (.clock(clock), .reset_n(reset_n), .special_mode(special_mode),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .analog_input(ain),
      .high_reference(hi_ref), .low_reference(lo_ref), .channel_sel(channel_sel),
      .sequence_irq(sequence_irq));
   initial begin
      foreach (ain[i]) ain[i] = 8'h0f + 8'(i) * 8'h1e;
      forever #12.5 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   function automatic logic [7:0] expv(input logic [7:0] m, input int k);
      logic [3:0] s;
      s = m[4] ? (m[6] ? {m[3], 3'(k)} : {m[3:2], 2'(k)}) : m[3:0];
      case (s[3:2])
         2'b10: expv = 8'h00;
         2'b11: expv = s[1:0] == 2'd0 ? hi_ref : s[1:0] == 2'd1 ? lo_ref :
            s[1:0] == 2'd2 ? 8'((9'(hi_ref) + 9'(lo_ref)) >> 1) : 8'h00;
         default: expv = ain[s[2:0]];
      endcase
   endfunction
   task automatic start(input logic [7:0] m);
      wr_reg(adcsq_pkg::OFS_MODE, m);
      rd_reg(adcsq_pkg::OFS_STAT0);
      `CHK("status", 8'h00, d)
      rd_reg(adcsq_pkg::OFS_STAT1);
      `CHK("flags", 8'h00, d)
   endtask
   task automatic wait_scf();
      int i;
      d = 8'h00;
      for (i = 0; i < 300 && d[7] !== 1'b1; i++) rd_reg(adcsq_pkg::OFS_STAT0);
      `CHK("scf", 1'b1, d[7])
   endtask
   task automatic poll_ccf0();
      int i;
      d = 8'h00;
      for (i = 0; i < 200 && d[0] !== 1'b1; i++) rd_reg(adcsq_pkg::OFS_STAT1);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rd_reg(adcsq_pkg::OFS_MODE);
      `CHK("mode reset", adcsq_pkg::RST_MODE, d)
      rd_reg(adcsq_pkg::OFS_CTL4);
      `CHK("ctl4 reset", adcsq_pkg::RST_CTL4, d)
      wr_reg(adcsq_pkg::OFS_MODE, 8'hff);
      rd_reg(adcsq_pkg::OFS_MODE);
      `CHK("mode rw", 8'h7f, d)
      wr_reg(adcsq_pkg::OFS_TEST, 8'h5a);
      rd_reg(adcsq_pkg::OFS_TEST);
      `CHK("test normal", 8'h00, d)
      wr_reg(adcsq_pkg::OFS_STAT1, 8'hff);
      rd_reg(adcsq_pkg::OFS_STAT1);
      `CHK("flags ro", 8'h00, d)
      special_mode <= 1'b1;
      wr_reg(adcsq_pkg::OFS_STAT1, 8'ha5);
      rd_reg(adcsq_pkg::OFS_STAT1);
      `CHK("flags special", 8'ha5, d)
      special_mode <= 1'b0;
      rd_reg(8'h6a);
      `CHK("unmapped", 8'h00, d)
      wr_reg(adcsq_pkg::OFS_CTL2, 8'h80);
      wr_reg(adcsq_pkg::OFS_CTL4, 8'h00);
      rd_reg(adcsq_pkg::OFS_CTL4);
      `CHK("ctl4 rw", 8'h00, d)
   endtask
   task automatic t_seq(input logic [7:0] m);
      int n;
      n = m[6] ? 8 : 4;
      start(m);
      wait_scf();
      rd_reg(adcsq_pkg::OFS_STAT1);
      `CHK("flags set", 8'((1 << n) - 1), d)
      for (int k = 0; k < n; k++) begin
         rd_reg(adcsq_pkg::OFS_RES0 + 8'(2 * k));
         `CHK("result", expv(m, k), d)
      end
      rd_reg(adcsq_pkg::OFS_STAT1);
      `CHK("flags read off", 8'h00, d)
   endtask
   task automatic t_single_stops();
      repeat (100) @(posedge clock);
      rd_reg(adcsq_pkg::OFS_STAT1);
      `CHK("single stops", 8'h00, d)
   endtask
   task automatic t_abort();
      int i;
      start(8'h50);
      d = 8'h00;
      for (i = 0; i < 100 && d === 8'h00; i++) rd_reg(adcsq_pkg::OFS_STAT1);
      `CHK("partial flags", 8'h01, d)
      t_seq(8'h17);
   endtask
   task automatic t_fast_irq();
      wr_reg(adcsq_pkg::OFS_CTL2, 8'hc2);
      start(8'h10);
      wait_scf();
      `CHK("irq", 1'b1, sequence_irq)
      rd_reg(adcsq_pkg::OFS_RES0 + 8'h04);
      `CHK("fast result", ain[2], d)
      rd_reg(adcsq_pkg::OFS_STAT0);
      `CHK("fast scf", 1'b0, d[7])
      rd_reg(adcsq_pkg::OFS_STAT1);
      `CHK("fast flags", 8'h0b, d)
      wr_reg(adcsq_pkg::OFS_CTL2, 8'h80);
      @(posedge clock);
      #1;
      `CHK("irq off", 1'b0, sequence_irq)
   endtask
   task automatic t_scan();
      start(8'h30);
      wait_scf();
      rd_reg(adcsq_pkg::OFS_RES0);
      `CHK("scan first", ain[0], d)
      ain[0] <= 8'h3c;
      repeat (2) begin
         poll_ccf0();
         rd_reg(adcsq_pkg::OFS_RES0);
      end
      `CHK("scan again", 8'h3c, d)
      wr_reg(adcsq_pkg::OFS_CTL2, 8'h00);
      repeat (100) @(posedge clock);
      rd_reg(adcsq_pkg::OFS_STAT0);
      `CHK("power off counter", 3'h0, d[2:0])
      rd_reg(adcsq_pkg::OFS_MODE);
      `CHK("power off access", 8'h30, d)
   endtask
   task automatic tally_and_finish();
      if (mismatches == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #500us;
      mismatches++;
      tally_and_finish();
   end
   initial begin
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      t_regs();
      foreach (modes[j]) t_seq(modes[j]);
      t_single_stops();
      t_abort();
      t_fast_irq();
      t_scan();
      tally_and_finish();
   end
endmodule
